/* File: hdl/dph_pkg.sv */
// shared constants for the debug power handshake
package dph_pkg;
  localparam int unsigned CSR_W = 32;
  localparam int unsigned DBG_REQ_BIT = 28;
  localparam int unsigned DBG_ACK_BIT = 29;
  localparam int unsigned SYS_REQ_BIT = 30;
  localparam int unsigned SYS_ACK_BIT = 31;
  localparam int unsigned LOST_BIT = 0;
  localparam logic [CSR_W-1:0] CSR_RESET = 32'h0000_0000;
  localparam logic [CSR_W-1:0] CSR_WMASK = 32'h5000_0001;
  localparam logic [1:0] REG_CSR = 2'h0;
  localparam logic [1:0] REG_CTL_STAT = 2'h1;
  localparam real CLK_MHZ = 50.0;
  localparam real PWR_UP_NS = 200.0;
  localparam real PWR_DN_NS = 100.0;
  localparam int unsigned PWR_UP_CYC =
    (int'($ceil(PWR_UP_NS * CLK_MHZ / 1000.0)) < 1) ? 1 :
    int'($ceil(PWR_UP_NS * CLK_MHZ / 1000.0));
  localparam int unsigned PWR_DN_CYC =
    (int'($ceil(PWR_DN_NS * CLK_MHZ / 1000.0)) < 1) ? 1 :
    int'($ceil(PWR_DN_NS * CLK_MHZ / 1000.0));
  localparam int unsigned CNT_W = 8;
  typedef enum logic [1:0] {DPH_OFF, DPH_RISE, DPH_ON, DPH_FALL} dph_dom_t;
endpackage

/* File: hdl/dph_if.sv */
// request and acknowledge wires between debug port and power controller
`timescale 1ns/1ps
interface dph_if;
  logic dbg_req;
  logic dbg_ack;
  logic sys_req;
  logic sys_ack;
  modport debug_port (output dbg_req, output sys_req,
    input dbg_ack, input sys_ack);
  modport power_ctrl (input dbg_req, input sys_req,
    output dbg_ack, output sys_ack);
endinterface

/* File: hdl/dph_debug_port.sv */
// debug port end: control/status register driving the power requests
`timescale 1ns/1ps
// Behaviour
// - debug request bit 28, ack bit 29
// - system request bit 30, ack bit 31
// - all request and ack signals active high
// - controller powers debug domain, then acks
// - controller powers system domain, then acks
// - already powered domain still acknowledged
// - ack held high while request high
// - system request honoured while held
// - debug domain powerdown emulated while held
// - system request emulates powerdown where shared
// - system request never without debug request
// - access transfers only when debug req/ack high
// - dropping request asks removal; ack falls after
// - acks reset low, rise only on request
// - controller powers down gracefully after drop
// - re-request only after ack reads low
// - request bits live in always-on domain
// - debug port stays powered during session
// - debugger can detect lost debug state
module dph_debug_port (
  input wire logic clock, // always-on clock
  input wire logic rst, // synchronous reset, high
  dph_if.debug_port pwr, // handshake to power controller
  input wire logic [1:0] addr, // register index
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  output logic xfer_ok, // access port transfer permitted
  output logic dbg_state_lost // debug state lost since last clear
);
  logic dbg_req_ff;
  logic sys_req_ff;
  logic [1:0] dack_sync_ff;
  logic [1:0] sack_sync_ff;
  logic lost_ff;
  logic ack_was_ff;
  logic [31:0] rdata_ff;
  logic [31:0] csr_view;
  logic [31:0] stat_view;
  logic wr_csr;
  logic nxt_dbg_req;
  logic nxt_sys_req;

  assign wr_csr = wr && (addr == dph_pkg::REG_CSR);

  // sys request forced low unless debug request also set
  always_comb begin
    nxt_dbg_req = dbg_req_ff;
    nxt_sys_req = sys_req_ff;
    if (wr_csr) begin
      nxt_dbg_req = wdata[dph_pkg::DBG_REQ_BIT];
      nxt_sys_req = wdata[dph_pkg::SYS_REQ_BIT] &&
        wdata[dph_pkg::DBG_REQ_BIT];
    end
  end

  // requests held in always-on flops, active high
  always_ff @(posedge clock) begin
    if (rst) begin
      dbg_req_ff <= 1'b0;
      sys_req_ff <= 1'b0;
    end else begin
      dbg_req_ff <= nxt_dbg_req;
      sys_req_ff <= nxt_sys_req;
    end
  end

  assign pwr.dbg_req = dbg_req_ff;
  assign pwr.sys_req = sys_req_ff;

  // acks come from another controller, so double-flop them
  always_ff @(posedge clock) begin
    if (rst) begin
      dack_sync_ff <= 2'h0;
      sack_sync_ff <= 2'h0;
    end else begin
      dack_sync_ff <= {dack_sync_ff[0], pwr.dbg_ack};
      sack_sync_ff <= {sack_sync_ff[0], pwr.sys_ack};
    end
  end

  // ack falling while still requested means the domain dropped
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_was_ff <= 1'b0;
      lost_ff <= 1'b0;
    end else begin
      ack_was_ff <= dack_sync_ff[1];
      if (ack_was_ff && !dack_sync_ff[1] && dbg_req_ff) begin
        lost_ff <= 1'b1;
      end else if (wr_csr && wdata[dph_pkg::LOST_BIT]) begin
        lost_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    csr_view = dph_pkg::CSR_RESET;
    csr_view[dph_pkg::DBG_REQ_BIT] = dbg_req_ff;
    csr_view[dph_pkg::DBG_ACK_BIT] = dack_sync_ff[1];
    csr_view[dph_pkg::SYS_REQ_BIT] = sys_req_ff;
    csr_view[dph_pkg::SYS_ACK_BIT] = sack_sync_ff[1];
    csr_view[dph_pkg::LOST_BIT] = lost_ff;
    stat_view = dph_pkg::CSR_RESET;
    stat_view[0] = xfer_ok;
    stat_view[1] = lost_ff;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= dph_pkg::CSR_RESET;
    end else if (rd) begin
      unique case (addr)
        dph_pkg::REG_CSR: rdata_ff <= csr_view;
        dph_pkg::REG_CTL_STAT: rdata_ff <= stat_view;
        default: rdata_ff <= dph_pkg::CSR_RESET;
      endcase
    end else begin
      rdata_ff <= dph_pkg::CSR_RESET;
    end
  end

  assign rdata = rdata_ff;
  assign xfer_ok = dbg_req_ff && dack_sync_ff[1];
  assign dbg_state_lost = lost_ff;
endmodule // dph_debug_port

/* File: hdl/dph_power_ctrl.sv */
// power controller end: per-domain powerup/ack sequencer
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module dph_power_ctrl (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset, high
  dph_if.power_ctrl pwr, // handshake from debug port
  input wire logic dbg_pd_req, // debug-domain component asks powerdown
  input wire logic sys_pd_req, // system-domain component asks powerdown
  input wire logic other_hold, // other parties need power kept
  output logic dbg_powered, // debug domain power and clocks on
  output logic sys_powered, // system domain power and clocks on
  output logic dbg_pd_emul, // debug-domain powerdown being emulated
  output logic sys_pd_emul // system-domain powerdown being emulated
);
  dph_pkg::dph_dom_t dbg_st_ff, sys_st_ff;
  logic [dph_pkg::CNT_W-1:0] dbg_cnt_ff, sys_cnt_ff;
  logic dbg_ack_ff, sys_ack_ff;
  logic dbg_on_ff, sys_on_ff;

  // one sequencer per domain; acks low from reset
  always_ff @(posedge clock) begin
    if (rst) begin
      dbg_st_ff <= dph_pkg::DPH_OFF;
      dbg_cnt_ff <= '0;
      dbg_ack_ff <= 1'b0;
      dbg_on_ff <= 1'b0;
    end else begin
      unique case (dbg_st_ff)
        dph_pkg::DPH_OFF: if (pwr.dbg_req) begin
          dbg_cnt_ff <= dbg_on_ff ? '0 :
            dph_pkg::CNT_W'(dph_pkg::PWR_UP_CYC);
          dbg_st_ff <= dph_pkg::DPH_RISE;
        end
        dph_pkg::DPH_RISE: begin
          dbg_on_ff <= 1'b1;
          if (dbg_cnt_ff == '0) begin
            dbg_ack_ff <= 1'b1;
            dbg_st_ff <= dph_pkg::DPH_ON;
          end else begin
            dbg_cnt_ff <= dbg_cnt_ff - 1'b1;
          end
        end
        dph_pkg::DPH_ON: if (!pwr.dbg_req) begin
          dbg_ack_ff <= 1'b0;
          dbg_cnt_ff <= dph_pkg::CNT_W'(dph_pkg::PWR_DN_CYC);
          dbg_st_ff <= dph_pkg::DPH_FALL;
        end
        dph_pkg::DPH_FALL: begin
          if (pwr.dbg_req) begin
            // still powered, so the new request is acked on the next cycle, with no powerup count
            dbg_cnt_ff <= '0;
            dbg_st_ff <= dph_pkg::DPH_RISE;
          end else if (pwr.sys_req || other_hold) begin
            // stay up; countdown restarts once the hold lifts
            dbg_cnt_ff <= dph_pkg::CNT_W'(dph_pkg::PWR_DN_CYC);
          end else if (dbg_cnt_ff == '0) begin
            dbg_on_ff <= 1'b0;
            dbg_st_ff <= dph_pkg::DPH_OFF;
          end else begin
            dbg_cnt_ff <= dbg_cnt_ff - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sys_st_ff <= dph_pkg::DPH_OFF;
      sys_cnt_ff <= '0;
      sys_ack_ff <= 1'b0;
      sys_on_ff <= 1'b0;
    end else begin
      unique case (sys_st_ff)
        dph_pkg::DPH_OFF: if (pwr.sys_req) begin
          sys_cnt_ff <= sys_on_ff ? '0 :
            dph_pkg::CNT_W'(dph_pkg::PWR_UP_CYC);
          sys_st_ff <= dph_pkg::DPH_RISE;
        end
        dph_pkg::DPH_RISE: begin
          sys_on_ff <= 1'b1;
          if (sys_cnt_ff == '0) begin
            sys_ack_ff <= 1'b1;
            sys_st_ff <= dph_pkg::DPH_ON;
          end else begin
            sys_cnt_ff <= sys_cnt_ff - 1'b1;
          end
        end
        dph_pkg::DPH_ON: if (!pwr.sys_req) begin
          sys_ack_ff <= 1'b0;
          sys_cnt_ff <= dph_pkg::CNT_W'(dph_pkg::PWR_DN_CYC);
          sys_st_ff <= dph_pkg::DPH_FALL;
        end
        dph_pkg::DPH_FALL: begin
          if (pwr.sys_req) begin
            sys_cnt_ff <= '0;
            sys_st_ff <= dph_pkg::DPH_RISE;
          end else if (other_hold) begin
            sys_cnt_ff <= dph_pkg::CNT_W'(dph_pkg::PWR_DN_CYC);
          end else if (sys_cnt_ff == '0) begin
            sys_on_ff <= 1'b0;
            sys_st_ff <= dph_pkg::DPH_OFF;
          end else begin
            sys_cnt_ff <= sys_cnt_ff - 1'b1;
          end
        end
      endcase
    end
  end

  assign pwr.dbg_ack = dbg_ack_ff;
  assign pwr.sys_ack = sys_ack_ff;
  assign dbg_powered = dbg_on_ff;
  assign sys_powered = sys_on_ff;
  // component powerdown is faked while the debugger holds the domain
  assign dbg_pd_emul = dbg_pd_req && pwr.dbg_req;
  assign sys_pd_emul = sys_pd_req && pwr.sys_req;
endmodule // dph_power_ctrl

/* File: sim/dph_handshake_assertions.sv */
// assertions on the request and acknowledge wires
`timescale 1ns/1ps
module dph_handshake_assertions (
  input wire logic clock, // clock
  input wire logic rst, // sync reset
  input wire logic dbg_req, // debug request
  input wire logic dbg_ack, // debug ack
  input wire logic sys_req, // system request
  input wire logic sys_ack // system ack
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence dbg_rise_s;
    $rose(dbg_req);
  endsequence
  sequence dbg_ack_s;
    !dbg_ack [*2] ##[1:12] dbg_ack;
  endsequence
  sequence sys_rise_s;
    $rose(sys_req);
  endsequence
  sequence sys_ack_s;
    !sys_ack [*2] ##[1:12] sys_ack;
  endsequence
  reset_low_a: assert property ($fell(rst) |-> !dbg_ack && !sys_ack)
    else $error("ack high after reset");
  ack_cause_a: assert property ($rose(dbg_ack) |-> dbg_req)
    else $error("debug ack rose without request");
  dbg_up_a: assert property (dbg_rise_s |-> dbg_ack_s)
    else $error("debug ack timing wrong");
  sys_up_a: assert property (sys_rise_s |-> sys_ack_s)
    else $error("system ack timing wrong");
  dbg_hold_a: assert property (dbg_req && dbg_ack |=> dbg_ack)
    else $error("debug ack dropped under request");
  sys_hold_a: assert property (sys_req && sys_ack |=> sys_ack)
    else $error("system ack dropped under request");
  sys_gate_a: assert property (sys_req |-> dbg_req)
    else $error("system request without debug request");
  dbg_drop_a: assert property (!dbg_req && dbg_ack |=> !dbg_ack)
    else $error("debug ack late to fall");
  sys_drop_a: assert property (!sys_req && sys_ack |=> !sys_ack)
    else $error("system ack late to fall");
endmodule // dph_handshake_assertions

/* File: sim/debug_power_handshake_tb_top.sv */
// self-checking bench joining both handshake ends
`timescale 1ns/1ps
module debug_power_handshake_tb_top;
  logic clock, rst, wr, rd, dbg_pd_req, sys_pd_req, other_hold;
  logic [1:0] addr;
  logic [31:0] wdata, rdata;
  logic xfer_ok, dbg_state_lost, dbg_powered, sys_powered;
  logic dbg_pd_emul, sys_pd_emul;
  int failures, comparisons;
  dph_if pwr_if();
  dph_debug_port i_dph_debug_port (.clock(clock), .rst(rst), .pwr(pwr_if),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .xfer_ok(xfer_ok), .dbg_state_lost(dbg_state_lost));
  dph_power_ctrl i_dph_power_ctrl (.clock(clock), .rst(rst), .pwr(pwr_if),
    .dbg_pd_req(dbg_pd_req), .sys_pd_req(sys_pd_req),
    .other_hold(other_hold), .dbg_powered(dbg_powered),
    .sys_powered(sys_powered), .dbg_pd_emul(dbg_pd_emul),
    .sys_pd_emul(sys_pd_emul));
  dph_handshake_assertions i_dph_handshake_assertions (.clock(clock),
    .rst(rst), .dbg_req(pwr_if.dbg_req), .dbg_ack(pwr_if.dbg_ack),
    .sys_req(pwr_if.sys_req), .sys_ack(pwr_if.sys_ack));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic end_of_test;
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // leaves time just inside the single cycle that rdata is valid
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input string nm, input logic [1:0] a,
    input logic [31:0] m, e);
    rd_reg(a);
    chk(nm, rdata & m, e);
  endtask
  task automatic poll(input logic [31:0] e);
    int n;
    n = 0;
    do begin
      rd_reg(2'h0);
      n++;
    end while ((rdata & 32'hF000_0000) !== e && n < 40);
    chk("csr_poll", rdata & 32'hF000_0000, e);
    if ((rdata & 32'hF000_0000) !== e) end_of_test;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    end_of_test;
  end
  initial begin
    rst = 1'b1;
    {wr, rd, dbg_pd_req, sys_pd_req, other_hold} = 5'h00;
    addr = 2'h0;
    wdata = 32'h0000_0000;
    failures = 0;
    comparisons = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd_chk("csr_reset", 2'h0, 32'hFFFF_FFFF, dph_pkg::CSR_RESET);
    rd_chk("status_reset", 2'h1, 32'h0000_0003, 32'h0000_0000);
    wr_reg(2'h3, 32'hFFFF_FFFF);
    rd_chk("unmapped", 2'h3, 32'hFFFF_FFFF, 32'h0000_0000);
    wr_reg(2'h0, 32'h4000_0000);
    rd_chk("sys_alone", 2'h0, 32'hF000_0000, 32'h0000_0000);
    wr_reg(2'h0, 32'h1000_0000);
    poll(32'h3000_0000);
    rd_chk("xfer_ok", 2'h1, 32'h0000_0001, 32'h0000_0001);
    chk("dbg_powered", {31'h0, dbg_powered}, 32'h0000_0001);
    wr_reg(2'h0, 32'h5000_0000);
    poll(32'hF000_0000);
    @(posedge clock);
    dbg_pd_req <= 1'b1;
    sys_pd_req <= 1'b1;
    @(posedge clock);
    #1 chk("pd_emul", {30'h0, dbg_pd_emul, sys_pd_emul}, 32'h3);
    chk("powered", {30'h0, dbg_powered, sys_powered}, 32'h3);
    @(posedge clock);
    dbg_pd_req <= 1'b0;
    sys_pd_req <= 1'b0;
    wr_reg(2'h0, 32'h1000_0000);
    poll(32'h3000_0000);
    // re-raise only once the ack reads low, domain still up
    wr_reg(2'h0, 32'h5000_0000);
    poll(32'hF000_0000);
    @(posedge clock);
    other_hold <= 1'b1;
    wr_reg(2'h0, 32'h0000_0000);
    poll(32'h0000_0000);
    repeat (dph_pkg::PWR_DN_CYC + 4) @(posedge clock);
    #1 chk("held", {31'h0, dbg_powered}, 32'h0000_0001);
    @(posedge clock);
    other_hold <= 1'b0;
    repeat (dph_pkg::PWR_DN_CYC + 4) @(posedge clock);
    #1 chk("off", {30'h0, dbg_powered, sys_powered}, 32'h0);
    chk("lost", {31'h0, dbg_state_lost}, 32'h0);
    end_of_test;
  end
endmodule // debug_power_handshake_tb_top
